/* File: include/bpd_regs.svh */
// constants of the breakpoint and debug-exception unit
// assumes a core pipeline presents one access and one retire per cycle
// Function
// - four breakpoint address registers each hold one linear breakpoint address
// - access of configured type hitting enabled breakpoint raises debug exception
// - type field 00 execute, 01 write, 11 read or write, 10 unused
// - size field 00 one byte, 01 two bytes, 11 four bytes
// - debug register moves allowed only at privilege level zero
// - execute breakpoint fires before the matching instruction executes
// - status register is never cleared by hardware after an exception
// - task-switch flag set when switching into task with trap bit set
// - single-step flag set when exception caused by single stepping
// - trace-step flag set raises exception after every executed instruction
// - all-tasks enable keeps breakpoint active and survives task switch
// - per-task enable is cleared on any task switch
// - access guard bit cleared whenever any debug exception occurs
// - one-byte trap instruction is taken as a code breakpoint
`ifndef BPD_REGS_SVH
`define BPD_REGS_SVH
`define BPD_SEL_ADDR0 3'h0
`define BPD_SEL_ADDR1 3'h1
`define BPD_SEL_ADDR2 3'h2
`define BPD_SEL_ADDR3 3'h3
`define BPD_SEL_STATUS 3'h6
`define BPD_SEL_CONTROL 3'h7
`define BPD_STAT_SS_BIT 14
`define BPD_STAT_TS_BIT 15
`define BPD_STAT_RESET 32'hFFFF0FF0
`define BPD_STAT_FIXED_MASK 32'hFFFF0FF0
`define BPD_CTRL_RESET 32'h00000400
`define BPD_CTRL_FIXED_ONE 32'h00000400
`define BPD_CTRL_WMASK 32'hFFFF23FF
`define BPD_CTRL_GUARD_BIT 13
`define BPD_CTRL_TYPE_LSB 16
`define BPD_TYPE_EXEC 2'h0
`define BPD_TYPE_WRITE 2'h1
`define BPD_TYPE_RW 2'h3
`define BPD_SIZE_BYTE 2'h0
`define BPD_SIZE_HALF 2'h1
`define BPD_SIZE_WORD 2'h3
`endif

/* File: include/bpd_pkg.sv */
// types of the breakpoint and debug-exception unit
// assumes bpd_regs.svh is included where constants are needed
package bpd_pkg;
	typedef enum logic [1:0] {
		BPD_ACC_NONE,
		BPD_ACC_EXEC,
		BPD_ACC_READ,
		BPD_ACC_WRITE
	} bpd_acc_e;
	typedef struct packed {
		logic valid;
		bpd_acc_e kind;
		logic [31:0] addr;
		logic [1:0] size;
	} bpd_access_s;
	typedef struct packed {
		logic valid;
		logic write;
		logic [2:0] sel;
		logic [31:0] wdata;
		logic [1:0] cpl;
	} bpd_move_s;
	typedef struct packed {
		logic [3:0] cond_hit;
		logic [3:0] enabled;
	} bpd_match_s;
endpackage

/* File: verilog/bpd_comparator.sv */
// one breakpoint comparator: address range, type and size match
// assumes access size uses the same encoding as the match size field
`timescale 1ns/1ps
`include "bpd_regs.svh"
module bpd_comparator
	import bpd_pkg::*;
(
	input wire logic [31:0] bp_addr,
	input wire logic [1:0] bp_type,
	input wire logic [1:0] bp_size,
	input wire bpd_access_s acc,
	output logic hit
);
	function automatic logic [2:0] span_bytes(input logic [1:0] sz);
		case (sz)
			`BPD_SIZE_HALF: span_bytes = 3'h2;
			`BPD_SIZE_WORD: span_bytes = 3'h4;
			default: span_bytes = 3'h1;
		endcase
	endfunction

	logic [32:0] bp_lo;
	logic [32:0] bp_hi;
	logic [32:0] ac_lo;
	logic [32:0] ac_hi;
	logic type_ok;
	logic size_ok;

	always_comb
	begin
		// range check on byte spans
		bp_lo = {1'b0, bp_addr};
		bp_hi = bp_lo + {30'h0, span_bytes(bp_size)};
		ac_lo = {1'b0, acc.addr};
		ac_hi = ac_lo + {30'h0, span_bytes(acc.size)};
		size_ok = (bp_size != 2'h2);
		case (bp_type)
			`BPD_TYPE_EXEC: type_ok = (acc.kind == BPD_ACC_EXEC);
			`BPD_TYPE_WRITE: type_ok = (acc.kind == BPD_ACC_WRITE);
			`BPD_TYPE_RW: type_ok = (acc.kind == BPD_ACC_READ) ||
				(acc.kind == BPD_ACC_WRITE);
			default: type_ok = 1'b0;
		endcase
		if (bp_type == `BPD_TYPE_EXEC)
			hit = acc.valid && type_ok && (acc.addr == bp_addr);
		else
			hit = acc.valid && type_ok && size_ok &&
				(ac_lo < bp_hi) && (bp_lo < ac_hi);
	end
endmodule // bpd_comparator

/* File: verilog/bpd_move_check.sv */
// permission check for a debug register move
// assumes the move request is valid for one cycle
`timescale 1ns/1ps
module bpd_move_check
	import bpd_pkg::*;
(
	input wire bpd_move_s mv,
	input wire logic guard,
	output logic allow,
	output logic priv_fault,
	output logic guard_trap
);
	always_comb
	begin
		priv_fault = mv.valid && (mv.cpl != 2'h0);
		guard_trap = mv.valid && !priv_fault && guard;
		allow = mv.valid && !priv_fault && !guard;
	end
endmodule // bpd_move_check

/* File: verilog/bpd_unit.sv */
// breakpoint registers, comparators and debug exception generation
// assumes the pipeline holds an instruction while dbg_exc is high
`timescale 1ns/1ps
`include "bpd_regs.svh"
module bpd_unit
	import bpd_pkg::*;
(
	input wire logic clock,
	input wire logic sys_rst,
	input wire bpd_access_s fetch,
	input wire bpd_access_s data,
	input wire logic retire,
	input wire logic trace_step_flag,
	input wire logic trap_insn,
	input wire logic task_switch,
	input wire logic task_switch_trap,
	input wire bpd_move_s move,
	output logic [31:0] move_rdata,
	output logic move_done,
	output logic priv_fault,
	output logic dbg_exc,
	output logic exec_break,
	output logic [31:0] debug_status,
	output logic [31:0] debug_control
);
	logic [31:0] bp_addr_q [4];
	logic [31:0] bp_addr_d [4];
	logic [31:0] stat_q;
	logic [31:0] stat_d;
	logic [31:0] ctrl_q;
	logic [31:0] ctrl_d;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic done_q;
	logic exc_q;
	logic exc_d;
	logic xbrk_q;
	logic xbrk_d;
	logic [3:0] f_hit;
	logic [3:0] d_hit;
	logic [3:0] enab;
	logic allow;
	logic guard_trap;
	logic any_exc;
	logic step_exc;
	bpd_match_s mt;

	function automatic logic [1:0] fld(input logic [31:0] c, input int i,
		input int off);
		fld = c[`BPD_CTRL_TYPE_LSB + 4 * i + off +: 2];
	endfunction

	for (genvar i = 0; i < 4; i++)
	begin : g_cmp
		bpd_comparator u_fetch (
			.bp_addr(bp_addr_q[i]),
			.bp_type(fld(ctrl_q, i, 0)),
			.bp_size(`BPD_SIZE_BYTE),
			.acc(fetch),
			.hit(f_hit[i])
		);
		bpd_comparator u_data (
			.bp_addr(bp_addr_q[i]),
			.bp_type(fld(ctrl_q, i, 0)),
			.bp_size(fld(ctrl_q, i, 2)),
			.acc(data),
			.hit(d_hit[i])
		);
		assign enab[i] = ctrl_q[2 * i] | ctrl_q[2 * i + 1];
	end

	bpd_move_check u_mchk (
		.mv(move),
		.guard(ctrl_q[`BPD_CTRL_GUARD_BIT]),
		.allow(allow),
		.priv_fault(priv_fault),
		.guard_trap(guard_trap)
	);

	always_comb
	begin
		mt.cond_hit = f_hit | d_hit;
		mt.enabled = enab;
		step_exc = retire && trace_step_flag;
		xbrk_d = |(f_hit & enab) || (fetch.valid && trap_insn);
		any_exc = |(mt.cond_hit & mt.enabled) || xbrk_d || step_exc ||
			guard_trap;
		exc_d = any_exc;
		for (int i = 0; i < 4; i++)
			bp_addr_d[i] = bp_addr_q[i];
		stat_d = stat_q;
		ctrl_d = ctrl_q;
		rdata_d = rdata_q;
		if (allow)
		begin
			if (move.write)
			begin
				case (move.sel)
					`BPD_SEL_ADDR0: bp_addr_d[0] = move.wdata;
					`BPD_SEL_ADDR1: bp_addr_d[1] = move.wdata;
					`BPD_SEL_ADDR2: bp_addr_d[2] = move.wdata;
					`BPD_SEL_ADDR3: bp_addr_d[3] = move.wdata;
					`BPD_SEL_STATUS: stat_d = (move.wdata &
						~`BPD_STAT_FIXED_MASK) | `BPD_STAT_RESET;
					`BPD_SEL_CONTROL: ctrl_d = (move.wdata & `BPD_CTRL_WMASK)
						| `BPD_CTRL_FIXED_ONE;
					default: rdata_d = rdata_q;
				endcase
			end
			else
			begin
				case (move.sel)
					`BPD_SEL_ADDR0: rdata_d = bp_addr_q[0];
					`BPD_SEL_ADDR1: rdata_d = bp_addr_q[1];
					`BPD_SEL_ADDR2: rdata_d = bp_addr_q[2];
					`BPD_SEL_ADDR3: rdata_d = bp_addr_q[3];
					`BPD_SEL_STATUS: rdata_d = stat_q;
					`BPD_SEL_CONTROL: rdata_d = ctrl_q;
					default: rdata_d = 32'h00000000;
				endcase
			end
		end
		// hardware status set after software write so the set wins
		if (any_exc)
		begin
			stat_d[3:0] = stat_d[3:0] | mt.cond_hit;
			if (step_exc)
				stat_d[`BPD_STAT_SS_BIT] = 1'b1;
			if (task_switch && task_switch_trap)
				stat_d[`BPD_STAT_TS_BIT] = 1'b1;
			ctrl_d[`BPD_CTRL_GUARD_BIT] = 1'b0;
		end
		// global enables in bits 1,3,5,7 are left untouched
		if (task_switch)
		begin
			ctrl_d[0] = 1'b0;
			ctrl_d[2] = 1'b0;
			ctrl_d[4] = 1'b0;
			ctrl_d[6] = 1'b0;
			if (task_switch_trap)
			begin
				exc_d = 1'b1;
				stat_d[`BPD_STAT_TS_BIT] = 1'b1;
				ctrl_d[`BPD_CTRL_GUARD_BIT] = 1'b0;
			end
		end
	end

	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			for (int i = 0; i < 4; i++)
				bp_addr_q[i] <= 32'h00000000;
			stat_q <= `BPD_STAT_RESET;
			ctrl_q <= `BPD_CTRL_RESET;
			rdata_q <= 32'h00000000;
			done_q <= 1'b0;
			exc_q <= 1'b0;
			xbrk_q <= 1'b0;
		end
		else
		begin
			for (int i = 0; i < 4; i++)
				bp_addr_q[i] <= bp_addr_d[i];
			stat_q <= stat_d;
			ctrl_q <= ctrl_d;
			rdata_q <= rdata_d;
			done_q <= allow;
			exc_q <= exc_d;
			xbrk_q <= xbrk_d;
		end
	end

	assign move_rdata = rdata_q;
	assign move_done = done_q;
	assign dbg_exc = exc_q;
	assign exec_break = xbrk_q;
	assign debug_status = stat_q;
	assign debug_control = ctrl_q;

	property p_priv;
		@(posedge clock) disable iff (sys_rst)
		(move.valid && move.cpl != 2'h0) |=> !move_done;
	endproperty
	a_priv: assert property (p_priv) else $error("move done at cpl>0");

	property p_guard_clear;
		@(posedge clock) disable iff (sys_rst)
		exc_d |=> !ctrl_q[`BPD_CTRL_GUARD_BIT];
	endproperty
	a_guard_clear: assert property (p_guard_clear)
		else $error("guard not cleared");

	property p_step;
		@(posedge clock) disable iff (sys_rst)
		(retire && trace_step_flag) |=> dbg_exc && stat_q[14];
	endproperty
	a_step: assert property (p_step) else $error("no step exception");

	property p_hit_disabled;
		@(posedge clock) disable iff (sys_rst)
		(any_exc && mt.cond_hit[0]) |=> stat_q[0];
	endproperty
	a_hit_disabled: assert property (p_hit_disabled)
		else $error("hit flag missing");

	property p_sticky;
		@(posedge clock) disable iff (sys_rst)
		(stat_q[0] && !(allow && move.write && move.sel == 3'h6)) |=>
			stat_q[0];
	endproperty
	a_sticky: assert property (p_sticky)
		else $error("status self-cleared");

	property p_local_clear;
		@(posedge clock) disable iff (sys_rst)
		task_switch |=> !ctrl_q[0] && !ctrl_q[2] && !ctrl_q[4] && !ctrl_q[6];
	endproperty
	a_local_clear: assert property (p_local_clear)
		else $error("local enable kept");

	property p_global_keep;
		@(posedge clock) disable iff (sys_rst)
		(task_switch && ctrl_q[1] && !allow) |=> ctrl_q[1];
	endproperty
	a_global_keep: assert property (p_global_keep)
		else $error("global enable lost");

	property p_exec_before;
		@(posedge clock) disable iff (sys_rst)
		(fetch.valid && |(f_hit & enab)) |=> exec_break && dbg_exc;
	endproperty
	a_exec_before: assert property (p_exec_before)
		else $error("exec break late");

	property p_trap;
		@(posedge clock) disable iff (sys_rst)
		(fetch.valid && trap_insn) |=> exec_break;
	endproperty
	a_trap: assert property (p_trap) else $error("trap insn missed");

	property p_ts;
		@(posedge clock) disable iff (sys_rst)
		(task_switch && task_switch_trap) |=> stat_q[15] && dbg_exc;
	endproperty
	a_ts: assert property (p_ts) else $error("task switch flag");

	property p_addr_write;
		@(posedge clock) disable iff (sys_rst)
		(allow && move.write && move.sel == `BPD_SEL_ADDR0) |=>
			bp_addr_q[0] == $past(move.wdata);
	endproperty
	a_addr_write: assert property (p_addr_write)
		else $error("address write lost");

	property p_data_hit;
		@(posedge clock) disable iff (sys_rst)
		(data.valid && |(d_hit & enab)) |=> dbg_exc;
	endproperty
	a_data_hit: assert property (p_data_hit)
		else $error("data break missed");

	property p_priv_keep;
		@(posedge clock) disable iff (sys_rst)
		(move.valid && move.cpl != 2'h0) |=>
			bp_addr_q[0] == $past(bp_addr_q[0]);
	endproperty
	a_priv_keep: assert property (p_priv_keep)
		else $error("address written at cpl>0");

	property p_guard_block;
		@(posedge clock) disable iff (sys_rst)
		guard_trap |=> dbg_exc && !move_done;
	endproperty
	a_guard_block: assert property (p_guard_block)
		else $error("guarded move performed");

	property p_size_unused;
		@(posedge clock) disable iff (sys_rst)
		(fld(ctrl_q, 0, 2) == 2'h2 && fld(ctrl_q, 0, 0) != `BPD_TYPE_EXEC)
			|-> !d_hit[0];
	endproperty
	a_size_unused: assert property (p_size_unused)
		else $error("unused size matched");

	property p_hit_flags;
		@(posedge clock) disable iff (sys_rst)
		any_exc |=> (stat_q[3:0] & $past(mt.cond_hit)) == $past(mt.cond_hit);
	endproperty
	a_hit_flags: assert property (p_hit_flags)
		else $error("hit flags not recorded");
endmodule // bpd_unit

/* File: verif/bpd_pipe_model.sv */
// pipeline and debug software model on the request side of the unit
// assumes the bench clock; all requests change on falling edges
`timescale 1ns/1ps
`include "bpd_regs.svh"
module bpd_pipe_model
	import bpd_pkg::*;
(
	input wire logic clock,
	input wire logic [31:0] move_rdata,
	input wire logic move_done,
	input wire logic priv_fault,
	output bpd_access_s fetch,
	output bpd_access_s data,
	output logic retire,
	output logic trace_step_flag,
	output logic trap_insn,
	output logic task_switch,
	output logic task_switch_trap,
	output bpd_move_s move
);
	// released buses show inverted stale addresses and write data; sel and size keep their last values
	task automatic rel();
		fetch = '{1'b0, BPD_ACC_NONE, ~fetch.addr, fetch.size};
		data = '{1'b0, BPD_ACC_NONE, ~data.addr, data.size};
		move = '{1'b0, 1'b0, move.sel, ~move.wdata, 2'h0};
		retire = 1'b0;
		trace_step_flag = 1'b0;
		trap_insn = 1'b0;
		task_switch = 1'b0;
		task_switch_trap = 1'b0;
	endtask
	task automatic mov(input logic wr, input logic [2:0] sel,
		input logic [31:0] wd, input logic [1:0] cpl,
		output logic done, output logic [31:0] rd, output logic pf);
		logic [31:0] v;
		v = wd;
		if (wr && sel == `BPD_SEL_CONTROL)
			v = (wd & `BPD_CTRL_WMASK) | `BPD_CTRL_FIXED_ONE;
		if (wr && sel == `BPD_SEL_STATUS)
			v = wd | `BPD_STAT_FIXED_MASK;
		@(negedge clock);
		move = '{1'b1, wr, sel, v, cpl};
		#1 pf = priv_fault;
		@(negedge clock);
		done = move_done;
		rd = move_rdata;
		rel();
	endtask
	task automatic acc(input logic f, input bpd_acc_e k,
		input logic [31:0] a, input logic [1:0] sz, input logic trap);
		@(negedge clock);
		if (f)
			fetch = '{1'b1, k, a, sz};
		else
			data = '{1'b1, k, a, sz};
		trap_insn = trap;
		@(negedge clock);
		rel();
	endtask
	task automatic ev(input logic r, input logic tr, input logic ts,
		input logic tt);
		@(negedge clock);
		retire = r;
		trace_step_flag = tr;
		task_switch = ts;
		task_switch_trap = tt;
		@(negedge clock);
		rel();
	endtask
	initial
	begin
		fetch = '0;
		data = '0;
		move = '0;
		rel();
	end
endmodule // bpd_pipe_model

/* File: verif/bpd_unit_tb.sv */
// self-checking bench of the breakpoint and debug-exception unit
// assumes bpd_pipe_model drives every request input
`timescale 1ns/1ps
`include "bpd_regs.svh"
module bpd_unit_tb
	import bpd_pkg::*;
;
	logic clock, sys_rst, retire, trace_step_flag, trap_insn;
	logic task_switch, task_switch_trap, move_done, priv_fault;
	logic dbg_exc, exec_break, dn, pf;
	logic [31:0] move_rdata, debug_status, debug_control, rd, st, ct;
	bpd_access_s fetch, data;
	bpd_move_s move;
	int mismatches, tests_run;
	logic [31:0] a [4] = '{32'h00001000, 32'h00001002, 32'h00003000,
		32'hFFFFFFFC};
	bpd_unit u_dut (.clock(clock), .sys_rst(sys_rst), .fetch(fetch),
		.data(data), .retire(retire), .trace_step_flag(trace_step_flag),
		.trap_insn(trap_insn), .task_switch(task_switch),
		.task_switch_trap(task_switch_trap), .move(move),
		.move_rdata(move_rdata), .move_done(move_done),
		.priv_fault(priv_fault), .dbg_exc(dbg_exc),
		.exec_break(exec_break), .debug_status(debug_status),
		.debug_control(debug_control));
	bpd_pipe_model u_pipe (.clock(clock), .move_rdata(move_rdata),
		.move_done(move_done), .priv_fault(priv_fault), .fetch(fetch),
		.data(data), .retire(retire), .trace_step_flag(trace_step_flag),
		.trap_insn(trap_insn), .task_switch(task_switch),
		.task_switch_trap(task_switch_trap), .move(move));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic exc(input logic e, input logic eb);
		chk(dbg_exc, e);
		chk(exec_break, eb);
		chk(debug_status, st);
		chk(debug_control, ct);
	endtask
	task automatic tally_and_finish();
		if (mismatches == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial
	begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	initial
	begin
		#(2000 * 50);
		mismatches++;
		tally_and_finish();
	end
	initial
	begin
		mismatches = 0;
		tests_run = 0;
		sys_rst = 1'b1;
		repeat (4) @(posedge clock);
		@(negedge clock);
		sys_rst = 1'b0;
		st = `BPD_STAT_RESET;
		ct = `BPD_CTRL_RESET;
		exc(1'b0, 1'b0);
		for (int i = 0; i < 4; i++)
			u_pipe.mov(1'b1, 3'(i), a[i], 2'h0, dn, rd, pf);
		for (int i = 0; i < 4; i++)
		begin
			u_pipe.mov(1'b0, 3'(i), 32'h0, 2'h0, dn, rd, pf);
			chk(rd, a[i]);
		end
		u_pipe.mov(1'b1, 3'h0, 32'h0000DEAD, 2'h3, dn, rd, pf);
		chk(pf, 1'b1);
		chk(dn, 1'b0);
		u_pipe.mov(1'b0, 3'h0, 32'h0, 2'h0, dn, rd, pf);
		chk(rd, a[0]);
		// bp0 write 4B local, bp1 rw 1B disabled, bp2 exec global
		ct = 32'h003D0421;
		u_pipe.mov(1'b1, 3'h7, ct, 2'h0, dn, rd, pf);
		exc(1'b0, 1'b0);
		u_pipe.acc(1'b0, BPD_ACC_READ, 32'h00001002, 2'h0, 1'b0);
		exc(1'b0, 1'b0);
		u_pipe.acc(1'b0, BPD_ACC_WRITE, 32'h00000FFF, 2'h1, 1'b0);
		st = st | 32'h1;
		exc(1'b1, 1'b0);
		u_pipe.acc(1'b0, BPD_ACC_WRITE, 32'h00001002, 2'h0, 1'b0);
		st = st | 32'h3;
		exc(1'b1, 1'b0);
		u_pipe.acc(1'b1, BPD_ACC_EXEC, 32'h00003000, 2'h0, 1'b0);
		st = st | 32'h4;
		exc(1'b1, 1'b1);
		u_pipe.acc(1'b1, BPD_ACC_EXEC, 32'h00005000, 2'h0, 1'b1);
		exc(1'b1, 1'b1);
		u_pipe.ev(1'b1, 1'b0, 1'b0, 1'b0);
		exc(1'b0, 1'b0);
		u_pipe.ev(1'b1, 1'b1, 1'b0, 1'b0);
		st = st | 32'h4000;
		exc(1'b1, 1'b0);
		u_pipe.ev(1'b0, 1'b0, 1'b1, 1'b1);
		st = st | 32'h8000;
		ct = 32'h003D0420;
		exc(1'b1, 1'b0);
		u_pipe.acc(1'b0, BPD_ACC_WRITE, 32'h00001000, 2'h3, 1'b0);
		exc(1'b0, 1'b0);
		u_pipe.mov(1'b1, 3'h7, ct | 32'h2000, 2'h0, dn, rd, pf);
		chk(debug_control, ct | 32'h2000);
		u_pipe.mov(1'b0, 3'h0, 32'h0, 2'h0, dn, rd, pf);
		chk(dn, 1'b0);
		exc(1'b1, 1'b0);
		u_pipe.mov(1'b1, 3'h6, 32'h0, 2'h0, dn, rd, pf);
		st = `BPD_STAT_RESET;
		exc(1'b0, 1'b0);
		tally_and_finish();
	end
endmodule // bpd_unit_tb
